// ---- lptac_pkg.sv ----
package lptac_pkg;

  // Clocking of the pulse engine
  localparam int SYS_CLK_HZ = 250_000_000;
  localparam int AFE_CLK_HZ = 4_000_000;
  localparam int AFE_DIV = SYS_CLK_HZ / AFE_CLK_HZ;
  localparam logic [5:0] AFE_DIV_LAST = 6'(AFE_DIV - 1);
  localparam int CONV_TIME_US = 50;
  localparam int CONV_TICKS = CONV_TIME_US * (AFE_CLK_HZ / 1_000_000);
  localparam logic [7:0] CONV_LAST = 8'(CONV_TICKS - 1);

  // Register word indexes, byte address is four times the index
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_TIMING_FIRST = 6'h01;
  localparam logic [5:0] IDX_PERIOD = 6'h1D;
  localparam logic [5:0] IDX_CONTROL = 6'h1E;
  localparam logic [5:0] IDX_LED_CURRENT = 6'h22;
  localparam logic [5:0] IDX_RESULT_FIRST = 6'h2A;
  localparam logic [5:0] IDX_RESULT_LAST = 6'h2D;
  localparam logic [5:0] IDX_DIFF_FIRST = 6'h2E;
  localparam logic [5:0] IDX_DIFF_LAST = 6'h2F;
  localparam logic [5:0] IDX_DIAG = 6'h30;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h31;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h32;
  localparam int TIMING_REGS = 29;
  localparam int PHASES = 14;

  // Field layouts
  localparam int CTL_NUMAV_LSB = 0;
  localparam int CTL_TIMER_BIT = 8;
  localparam int CTL_THIRD_BIT = 9;
  localparam int LED_RED_LSB = 0;
  localparam int LED_IR_LSB = 8;
  localparam int IRQ_DRDY = 0;
  localparam int IRQ_POS_FAULT = 1;
  localparam int IRQ_NEG_FAULT = 2;
  localparam int IRQ_W = 3;

  // Reset values
  localparam logic [15:0] TIMING_RST = 16'h0000;
  localparam logic [7:0] NUMAV_RST = 8'h00;
  localparam logic [7:0] LED_CODE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Phase vector, bit k is the phase whose start sits at index 2k+1
  typedef struct packed {
    logic [3:0] adc_reset;
    logic [3:0] convert;
    logic ir_amb;
    logic ir_led;
    logic ir_sample;
    logic red_amb;
    logic red_led;
    logic red_sample;
  } lptac_phase_s;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_RUN = 1'b1
  } lptac_conv_e;

endpackage : lptac_pkg

// ---- lptac_phase_gen.sv ----
`timescale 1ns/1ps
module lptac_phase_gen
  import lptac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic enable,
  input wire logic [TIMING_REGS:1][15:0] cfg,
  // Phases
  output lptac_phase_s phase_o
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [PHASES-1:0] on_w;
  logic [PHASES-1:0] empty_w;
  logic [PHASES-1:0] phase_reg;

  // Period counter wraps after the programmed last count
  assign count_next = (count_reg >= cfg[TIMING_REGS]) ? 16'h0000 : count_reg + 16'h0001;

  // Inclusive window compare, inverted bounds give no pulse
  for (genvar k = 0; k < PHASES; k++) begin : g_cmp
    assign empty_w[k] = cfg[2*k+1] > cfg[2*k+2];
    assign on_w[k] = !empty_w[k] && (count_reg >= cfg[2*k+1]) && (count_reg <= cfg[2*k+2]);
  end

  // Counter held at zero while the engine is off
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      count_reg <= 16'h0000;
    end else if (tick) begin
      count_reg <= count_next;
    end
  end

  // Phases registered; all low while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= on_w;
    end
  end

  assign phase_o = lptac_phase_s'(phase_reg);

  zero_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (phase_reg & $past(empty_w)) == '0)
    else $error("phase asserted with start above end");

  count_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (enable && tick && count_reg >= cfg[TIMING_REGS]) |=> (count_reg == 16'h0000))
    else $error("period counter did not wrap");

endmodule : lptac_phase_gen

// ---- lptac_top.sv ----
`timescale 1ns/1ps
module lptac_top
  import lptac_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // LED drive
  output logic led_out_positive,
  output logic led_out_negative,
  output logic led_out_third,
  output logic led_drive_on,
  output logic [7:0] red_led_code,
  output logic [7:0] infrared_led_code,
  // Converter
  output logic adc_reset,
  output logic adc_convert_start,
  input wire logic [21:0] adc_code,
  input wire logic adc_code_valid,
  // Diagnostics
  input wire logic diag_positive_fault,
  input wire logic diag_negative_fault,
  input wire logic diag_third_fault,
  // Interrupts
  output logic adc_ready,
  output logic irq
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Register state
  logic [TIMING_REGS:1][15:0] timing_reg;
  logic [7:0] numav_reg;
  logic timing_engine_enable_reg;
  logic third_led_select_reg;
  logic [7:0] red_code_reg;
  logic [7:0] ir_code_reg;
  logic [3:0][23:0] result_reg;
  logic [1:0][23:0] diff_reg;
  logic [1:0] diag_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [1:0] fault_prev_reg;

  // Bus handshake state
  logic awready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Engine state
  logic [5:0] div_cnt_reg;
  logic tick_reg;
  lptac_phase_s ph;
  logic [3:0] rst_prev_reg;
  lptac_conv_e conv_state_reg;
  logic [7:0] conv_cnt_reg;
  logic [7:0] conv_left_reg;
  logic start_reg;
  logic signed [31:0] acc_reg;
  logic [8:0] nsamp_reg;

  // Output flops
  logic led_pos_reg;
  logic led_neg_reg;
  logic led_third_reg;
  logic led_drive_on_reg;
  logic adc_reset_reg;
  logic adc_ready_reg;
  logic irq_reg;

  // Merge new bytes into a word under the strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : strb_merge

  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx >= IDX_TIMING_FIRST && idx <= IDX_CONTROL) || idx == IDX_LED_CURRENT ||
           (idx >= IDX_RESULT_FIRST && idx <= IDX_IRQ_MASK);
  endfunction : is_mapped

  // Reads of registers; used for read data and byte-merge on write
  function automatic logic [31:0] reg_value(input logic [5:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx >= IDX_TIMING_FIRST && idx <= IDX_PERIOD) begin
      v[15:0] = timing_reg[idx];
    end else if (idx == IDX_CONTROL) begin
      v[CTL_NUMAV_LSB +: 8] = numav_reg;
      v[CTL_TIMER_BIT] = timing_engine_enable_reg;
      v[CTL_THIRD_BIT] = third_led_select_reg;
    end else if (idx == IDX_LED_CURRENT) begin
      v[LED_RED_LSB +: 8] = red_code_reg;
      v[LED_IR_LSB +: 8] = ir_code_reg;
    end else if (idx >= IDX_RESULT_FIRST && idx <= IDX_RESULT_LAST) begin
      v[23:0] = result_reg[2'(idx - IDX_RESULT_FIRST)];
    end else if (idx >= IDX_DIFF_FIRST && idx <= IDX_DIFF_LAST) begin
      v[23:0] = diff_reg[1'(idx - IDX_DIFF_FIRST)];
    end else if (idx == IDX_DIAG) begin
      v[1:0] = diag_reg;
    end else if (idx == IDX_IRQ_STATUS) begin
      v[IRQ_W-1:0] = irq_status_reg;
    end else if (idx == IDX_IRQ_MASK) begin
      v[IRQ_W-1:0] = irq_mask_reg;
    end
    return v;
  endfunction : reg_value

  // Running sum divided by the samples taken
  function automatic logic [23:0] avg_of(input logic signed [31:0] acc, input logic [8:0] n);
    logic signed [31:0] q;
    q = (n == 9'h000) ? 32'sh0 : acc / $signed({23'h0, n});
    return q[23:0];
  endfunction : avg_of

  // Write and read decode
  logic aw_hit;
  logic wr_en;
  logic [5:0] wr_idx;
  logic [31:0] wr_word;
  logic ar_hit;
  logic [5:0] rd_idx;
  logic [31:0] rd_word;
  logic [31:0] wr_old;

  assign aw_hit = awvalid && wvalid && !awready_reg && !bvalid_reg;
  assign wr_en = awready_reg;
  assign wr_idx = awaddr[7:2];
  assign ar_hit = arvalid && !arready_reg && !rvalid_reg;
  assign rd_idx = araddr[7:2];
  assign wr_word = strb_merge(wr_old, wdata, wstrb);

  always_comb begin
    wr_old = reg_value(wr_idx);
    rd_word = reg_value(rd_idx);
  end

  // Both channels taken in one cycle; master holds them until then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      awready_reg <= aw_hit;
      if (wr_en) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= ar_hit;
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_reg <= {TIMING_REGS{TIMING_RST}};
      numav_reg <= NUMAV_RST;
      timing_engine_enable_reg <= 1'b0;
      third_led_select_reg <= 1'b0;
      red_code_reg <= LED_CODE_RST;
      ir_code_reg <= LED_CODE_RST;
      irq_mask_reg <= IRQ_RST;
    end else if (wr_en) begin
      if (wr_idx >= IDX_TIMING_FIRST && wr_idx <= IDX_PERIOD) begin
        timing_reg[wr_idx] <= wr_word[15:0];
      end else if (wr_idx == IDX_CONTROL) begin
        numav_reg <= wr_word[CTL_NUMAV_LSB +: 8];
        timing_engine_enable_reg <= wr_word[CTL_TIMER_BIT];
        third_led_select_reg <= wr_word[CTL_THIRD_BIT];
      end else if (wr_idx == IDX_LED_CURRENT) begin
        red_code_reg <= wr_word[LED_RED_LSB +: 8];
        ir_code_reg <= wr_word[LED_IR_LSB +: 8];
      end else if (wr_idx == IDX_IRQ_MASK) begin
        irq_mask_reg <= wr_word[IRQ_W-1:0];
      end
    end
  end

  // 4 MHz enable; the divide rounds down, so ticks run a little fast
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      div_cnt_reg <= (div_cnt_reg == AFE_DIV_LAST) ? 6'h00 : div_cnt_reg + 6'h01;
      tick_reg <= (div_cnt_reg == AFE_DIV_LAST);
    end
  end

  lptac_phase_gen u_phase (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_reg),
    .enable(timing_engine_enable_reg),
    .cfg(timing_reg),
    .phase_o(ph)
  );

  // LED windows with ambient sampling forcing the drive off
  logic red_on;
  logic ir_on;
  logic amb_any;
  assign amb_any = ph.red_amb || ph.ir_amb;
  assign red_on = ph.red_led && !amb_any;
  assign ir_on = ph.ir_led && !amb_any;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_pos_reg <= 1'b0;
      led_third_reg <= 1'b0;
      led_neg_reg <= 1'b0;
      led_drive_on_reg <= 1'b0;
    end else begin
      led_pos_reg <= red_on && !third_led_select_reg;
      led_third_reg <= red_on && third_led_select_reg;
      led_neg_reg <= ir_on;
      led_drive_on_reg <= red_on || ir_on;
    end
  end

  // ADC reset edges
  logic [3:0] rst_rise;
  logic [3:0] rst_fall;
  logic rise_any;
  logic fall_any;
  logic [1:0] rise_idx;
  logic [1:0] res_idx;
  logic [23:0] avg_w;
  assign rst_rise = ph.adc_reset & ~rst_prev_reg;
  assign rst_fall = ~ph.adc_reset & rst_prev_reg;
  assign rise_any = |rst_rise;
  assign fall_any = |rst_fall;
  assign rise_idx = rst_rise[3] ? 2'h3 : rst_rise[2] ? 2'h2 : rst_rise[1] ? 2'h1 : 2'h0;
  assign res_idx = rise_idx - 2'h1;
  assign avg_w = avg_of(acc_reg, nsamp_reg);

  // Conversion sequencer: NUMAV+1 back-to-back 50 us conversions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_prev_reg <= 4'h0;
      conv_state_reg <= CONV_IDLE;
      conv_cnt_reg <= 8'h00;
      conv_left_reg <= 8'h00;
      start_reg <= 1'b0;
    end else begin
      rst_prev_reg <= ph.adc_reset;
      start_reg <= 1'b0;
      if (fall_any) begin
        conv_state_reg <= CONV_RUN;
        conv_cnt_reg <= 8'h00;
        conv_left_reg <= numav_reg;
        start_reg <= 1'b1;
      end else begin
        case (conv_state_reg)
          CONV_IDLE: begin
            conv_cnt_reg <= 8'h00;
          end
          CONV_RUN: begin
            if (tick_reg && conv_cnt_reg == CONV_LAST) begin
              conv_cnt_reg <= 8'h00;
              if (conv_left_reg != 8'h00) begin
                conv_left_reg <= conv_left_reg - 8'h01;
                start_reg <= 1'b1;
              end else begin
                conv_state_reg <= CONV_IDLE;
              end
            end else if (tick_reg) begin
              conv_cnt_reg <= conv_cnt_reg + 8'h01;
            end
          end
          default: conv_state_reg <= CONV_IDLE;
        endcase
      end
    end
  end

  // Accumulate sign-extended samples of the current phase
  always_ff @(posedge aclk) begin
    if (!aresetn || fall_any) begin
      acc_reg <= 32'sh0;
      nsamp_reg <= 9'h000;
    end else if (adc_code_valid) begin
      acc_reg <= acc_reg + {{10{adc_code[21]}}, adc_code};
      nsamp_reg <= nsamp_reg + 9'h001;
    end
  end

  // Result and difference registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= '0;
      diff_reg <= '0;
    end else if (rise_any) begin
      result_reg[res_idx] <= avg_w;
      diff_reg[res_idx[1]] <= res_idx[0] ? result_reg[{res_idx[1], 1'b0}] - avg_w
                                         : avg_w - result_reg[{res_idx[1], 1'b1}];
    end
  end

  // Diagnostics and sticky interrupt status, set wins over clear
  logic pos_fault_sel;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  assign pos_fault_sel = third_led_select_reg ? diag_third_fault : diag_positive_fault;
  assign irq_set = {diag_negative_fault && !fault_prev_reg[1], pos_fault_sel && !fault_prev_reg[0], rst_rise[0]};
  assign irq_clr = (wr_en && wr_idx == IDX_IRQ_STATUS) ? wr_word[IRQ_W-1:0] & wdata[IRQ_W-1:0] : IRQ_RST;
  assign irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_reg <= 2'h0;
      fault_prev_reg <= 2'h0;
      irq_status_reg <= IRQ_RST;
      irq_reg <= 1'b0;
      adc_reset_reg <= 1'b0;
      adc_ready_reg <= 1'b0;
    end else begin
      diag_reg <= {diag_negative_fault, pos_fault_sel};
      fault_prev_reg <= {diag_negative_fault, pos_fault_sel};
      irq_status_reg <= irq_status_next;
      irq_reg <= |(irq_status_reg & irq_mask_reg);
      adc_reset_reg <= |ph.adc_reset;
      adc_ready_reg <= ph.adc_reset[0];
    end
  end

  // Port drive
  assign awready = awready_reg;
  assign wready = awready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign led_out_positive = led_pos_reg;
  assign led_out_negative = led_neg_reg;
  assign led_out_third = led_third_reg;
  assign led_drive_on = led_drive_on_reg;
  assign red_led_code = red_code_reg;
  assign infrared_led_code = ir_code_reg;
  assign adc_reset = adc_reset_reg;
  assign adc_convert_start = start_reg;
  assign adc_ready = adc_ready_reg;
  assign irq = irq_reg;

  sequence s_reset_end;
    fall_any;
  endsequence

  third_route_a: assert property ($past(red_on) && $past(third_led_select_reg)
    |-> led_out_third && !led_out_positive)
    else $error("red drive not moved to third output");
  ambient_dark_a: assert property (amb_any |=> !led_drive_on && !led_out_positive)
    else $error("LED driven during ambient phase");
  diag_select_a: assert property (third_led_select_reg |=> diag_reg[0] == $past(diag_third_fault))
    else $error("positive fault not taken from third output");
  conv_start_a: assert property (s_reset_end |=> adc_convert_start ##1 !adc_convert_start)
    else $error("conversion did not start after reset end");
  result_order_a: assert property (rst_rise[1] |=> result_reg[0] == $past(avg_w))
    else $error("first result not stored at second reset");
  diff_update_a: assert property (rst_rise[2] |=> diff_reg[0] == result_reg[0] - result_reg[1])
    else $error("difference not refreshed");
  data_ready_a: assert property (rst_rise[0] |=> adc_ready && irq_status_reg[IRQ_DRDY])
    else $error("data ready missing at first reset");
  irq_level_a: assert property (|(irq_status_reg & irq_mask_reg) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule : lptac_top

// ---- lptac_adc_model.sv ----
`timescale 1ns/1ps
module lptac_adc_model
  import lptac_pkg::*;
#(
  parameter logic [3:0][21:0] CODES = '0
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Conversion handshake
  input wire logic adc_convert_start,
  output logic [21:0] adc_code,
  output logic adc_code_valid
);
  logic [1:0] n_reg;
  logic busy_reg;
  int wait_reg;

  // One sample per start, alternating a prompt and a slow answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_reg <= 2'h0;
      busy_reg <= 1'b0;
      wait_reg <= 0;
      adc_code_valid <= 1'b0;
      adc_code <= 22'h155555;
    end else begin
      adc_code_valid <= 1'b0;
      adc_code <= ~adc_code; // Code is not held outside the valid cycle
      if (adc_convert_start) begin
        busy_reg <= 1'b1;
        wait_reg <= n_reg[0] ? 70 : 3;
      end else if (busy_reg && wait_reg == 0) begin
        busy_reg <= 1'b0;
        adc_code_valid <= 1'b1;
        adc_code <= CODES[n_reg];
        n_reg <= n_reg + 2'h1;
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 1;
      end
    end
  end
endmodule : lptac_adc_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import lptac_pkg::*;
  localparam int PER = 40 * AFE_DIV;
  localparam int ON = 8 * AFE_DIV;
  localparam logic [3:0][21:0] CODES = {22'h000009, 22'h000005, 22'h00001E, 22'h000064};
  // Red LED 2..15 overlaps red ambient 10..20; IR LED 30..25 is empty
  localparam logic [5:0] TIX [15] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h09, 6'h0A, 6'h15, 6'h16,
    6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D};
  localparam logic [15:0] TVAL [15] = '{16'h0002, 16'h000F, 16'h000A, 16'h0014, 16'h001E, 16'h0019,
    16'h0000, 16'h0005, 16'h000A, 16'h000F, 16'h0014, 16'h0019, 16'h001E, 16'h0023, 16'h0027};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, red_led_code, infrared_led_code;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic led_out_positive, led_out_negative, led_out_third, led_drive_on, adc_reset, adc_convert_start;
  logic adc_code_valid, diag_positive_fault, diag_negative_fault, diag_third_fault, adc_ready, irq;
  logic [21:0] adc_code;
  int n_errors, compares, cyc;
  int cnt [6];

  lptac_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .led_out_positive, .led_out_negative, .led_out_third, .led_drive_on, .red_led_code,
    .infrared_led_code, .adc_reset, .adc_convert_start, .adc_code, .adc_code_valid,
    .diag_positive_fault, .diag_negative_fault, .diag_third_fault, .adc_ready, .irq);

  lptac_adc_model #(.CODES(CODES)) model_u (.aclk, .aresetn, .adc_convert_start, .adc_code,
    .adc_code_valid);

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Hang guard, roughly twice the planned run
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // Address and data offered together, each released once taken
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] resp);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk(32'(bresp), 32'(resp), "write response");
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [1:0] resp);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_data = rdata;
    rready <= 1'b0;
    chk(32'(rresp), 32'(resp), "read response");
  endtask : rd

  // Counts over one whole period, so alignment does not matter
  task automatic measure(input int p, input int t, input int r, input int s);
    logic prev;
    int fall;
    cnt = '{default: 0};
    prev = (adc_reset === 1'b1);
    fall = -1;
    for (int i = 0; i < PER; i++) begin
      @(posedge aclk);
      cnt[0] += int'(led_out_positive === 1'b1);
      cnt[1] += int'(led_out_negative === 1'b1);
      cnt[2] += int'(led_out_third === 1'b1);
      cnt[3] += int'(led_drive_on === 1'b1);
      cnt[4] += int'(adc_ready === 1'b1);
      cnt[5] += int'(adc_convert_start === 1'b1);
      if (prev && adc_reset === 1'b0) fall = i;
      // Start rises in the first cycle that the reset output reads low
      if (adc_convert_start === 1'b1) chk(32'(i - fall), 32'h0, "start after reset fall");
      prev = (adc_reset === 1'b1);
    end
    chk(32'(cnt[0]), 32'(p), "positive drive cycles");
    chk(32'(cnt[1]), 32'h0, "negative drive cycles");
    chk(32'(cnt[2]), 32'(t), "third drive cycles");
    chk(32'(cnt[3]), 32'(p + t), "drive on cycles");
    chk(32'(cnt[4]), 32'(r), "data ready cycles");
    chk(32'(cnt[5]), 32'(s), "convert starts");
  endtask : measure

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {diag_positive_fault, diag_negative_fault, diag_third_fault} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped place
    rd(IDX_CONTROL, RESP_OKAY);
    chk(rd_data, 32'h0, "control reset");
    rd(IDX_IRQ_STATUS, RESP_OKAY);
    chk(rd_data, 32'h0, "status reset");
    rd(6'h3F, RESP_SLVERR);
    chk(rd_data, 32'h0, "unmapped read");
    wr(6'h3F, 32'hFFFF, RESP_SLVERR);
    // Separate 8-bit current codes
    wr(IDX_LED_CURRENT, 32'h0000A55A, RESP_OKAY);
    chk(32'(red_led_code), 32'h5A, "red code");
    chk(32'(infrared_led_code), 32'hA5, "infrared code");
    rd(IDX_LED_CURRENT, RESP_OKAY);
    chk(rd_data, 32'h0000A55A, "current readback");
    // Pulse table with six-tick converter resets
    for (int k = 0; k < 15; k++) wr(TIX[k], 32'(TVAL[k]), RESP_OKAY);
    rd(6'h04, RESP_OKAY);
    chk(rd_data, 32'h0000000F, "timing readback");
    wr(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
    wr(IDX_CONTROL, 32'h100, RESP_OKAY);
    repeat (PER) @(posedge aclk);
    measure(ON, 0, 6 * AFE_DIV, 4);
    // Results after two full periods
    for (int k = 0; k < 4; k++) begin
      rd(IDX_RESULT_FIRST + 6'(k), RESP_OKAY);
      chk(32'(rd_data[21:0]), 32'(CODES[k]), "result code");
      chk(32'(rd_data[31:24]), 32'h0, "result width");
    end
    rd(IDX_DIFF_FIRST, RESP_OKAY);
    chk(32'(rd_data[21:0]), 32'd70, "first difference");
    rd(IDX_DIFF_LAST, RESP_OKAY);
    chk(32'(rd_data[21:0]), 32'h003FFFFC, "second difference");
    // Third output takes over, static for whole periods
    wr(IDX_CONTROL, 32'h300, RESP_OKAY);
    // Nothing analog settles here, so one period stands in for the settle wait
    repeat (PER) @(posedge aclk);
    measure(0, ON, 6 * AFE_DIV, 4);
    diag_positive_fault <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(irq), 32'h0, "positive fault ignored");
    diag_third_fault <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(irq), 32'h1, "third fault irq");
    rd(IDX_DIAG, RESP_OKAY);
    chk(rd_data, 32'h1, "diag under third");
    wr(IDX_IRQ_STATUS, 32'h2, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0, "fault cleared");
    // Data ready sticky bit behind the mask
    wr(IDX_IRQ_MASK, 32'h1, RESP_OKAY);
    repeat (PER) @(posedge aclk);
    chk(32'(irq), 32'h1, "data ready irq");
    wr(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 32'h1, RESP_OKAY);
    repeat (PER) @(posedge aclk);
    rd(IDX_IRQ_STATUS, RESP_OKAY);
    chk(rd_data, 32'h1, "status while masked");
    chk(32'(irq), 32'h0, "masked irq");
    // Idle: engine off, no drive
    wr(IDX_CONTROL, 32'h0, RESP_OKAY);
    repeat (PER) @(posedge aclk);
    measure(0, 0, 0, 0);
    give_verdict();
  end
endmodule : testbench
